// file: verilog/bep_regs.svh
// Purpose: offsets, fields, resets and codes of the bridge registers
// Assumes: included by bare name, after the package
// Notes: definitions only
//
// Overview of operation
// - Posted io check acts on policy code
// - Nonfatal status shows nonfatal wire state
// - Write one clears nonfatal; reads zero
// - Fatal status shows fatal wire state
// - Write one clears fatal; reads zero
// - SCI status set while forcing SCI low
// - Write one clears SCI status, releases
// - SMI status set while forcing SMI low
// - Write one clears SMI status, releases
// - Read-only revision, sub id, device ids
// - Lock flag reads oscillator locked state
// - Force bit uses oscillator even unlocked
// - Deep sleep on C10 when all idle
// - Oscillator off during deep sleep
`ifndef BEP_REGS_SVH
`define BEP_REGS_SVH

// ==========================================
// Register indexes
`define BEP_IDX_POLICY 8'h10
`define BEP_IDX_WIRE 8'h12
`define BEP_IDX_EVENT 8'h13
`define BEP_IDX_REV 8'h1c
`define BEP_IDX_SUB 8'h1d
`define BEP_IDX_ID_LO 8'h1e
`define BEP_IDX_ID_HI 8'h1f
`define BEP_IDX_LEG_ID 8'h20
`define BEP_IDX_LEG_REV 8'h21
`define BEP_IDX_POWER 8'h2a

// ==========================================
// Field positions
`define BEP_POLICY_MSB 3
`define BEP_FATAL_STS_BIT 0
`define BEP_FATAL_CLR_BIT 1
`define BEP_NONFATAL_STS_BIT 4
`define BEP_NONFATAL_CLR_BIT 5
`define BEP_SMI_STS_BIT 0
`define BEP_SMI_CLR_BIT 1
`define BEP_SCI_STS_BIT 4
`define BEP_SCI_CLR_BIT 5
`define BEP_DEEP_SLEEP_BIT 0
`define BEP_IDLE_GATE_BIT 1
`define BEP_FORCE_OSC_BIT 6
`define BEP_OSC_LOCK_BIT 7

// ==========================================
// Policy codes and reset values
`define BEP_POL_IGNORE 4'h0
`define BEP_POL_NONFATAL 4'h1
`define BEP_POL_FATAL 4'h2
`define BEP_POL_SMI 4'h3
`define BEP_POL_SCI 4'h4
`define BEP_RST_POLICY 4'h0
`define BEP_RST_BYTE 8'h00

`endif

// file: verilog/bep_pkg.sv
// Purpose: types shared by the bridge register bank
// Assumes: nothing
// Notes: constants live in bep_regs.svh
package bep_pkg;

	// ==========================================
	// Deep sleep states, Gray from run to sleep to wake
	typedef enum logic [1:0] {
		BEP_RUN = 2'b00,
		BEP_SLEEP = 2'b01,
		BEP_WAKE = 2'b11
	} bep_power_state_type;

	// ==========================================
	// Configuration portal access
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] index;
		logic [7:0] wdata;
	} bep_cfg_req_type;

	// ==========================================
	// Interface idle indications
	typedef struct packed {
		logic espi;
		logic lpc;
		logic serirq;
		logic lpc_clk;
	} bep_idle_type;

endpackage : bep_pkg

// file: verilog/bep_top.sv
// Purpose: error policy, error status, identity and power save registers
// Assumes: portal accesses are one-cycle strobes on the reference clock
// Notes: virtual wires face the link on their own clock
`timescale 1ns/1ps
`include "bep_regs.svh"

module bep_top #(
	parameter int NUM_FUNCS = 4,
	parameter logic [7:0] CHIP_REVISION = 8'h11, // Arbitrary value
	parameter logic [7:0] CHIP_SUB_ID = 8'h22, // Arbitrary value
	parameter logic [7:0] CHIP_ID_LOW = 8'h33, // Arbitrary value
	parameter logic [7:0] CHIP_ID_HIGH = 8'h44, // Arbitrary value
	parameter logic [7:0] LEGACY_ID = 8'h55, // Arbitrary value
	parameter logic [7:0] LEGACY_REV = 8'h66 // Arbitrary value
) (
	// Clock, resets, enable
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic i_espi_rst,
	input wire logic i_clk_en,
	// Configuration portal
	input wire bep_pkg::bep_cfg_req_type i_cfg_req,
	output logic [7:0] o_cfg_rdata,
	output logic o_cfg_rvalid,
	// Cycle engine and pins
	input wire logic i_io_check_signal_n,
	input wire logic i_posted_write_active,
	input wire logic i_oscillator_locked,
	input wire bep_pkg::bep_idle_type i_idle,
	input wire logic [NUM_FUNCS-1:0] i_func_idle,
	// Oscillator and clock control
	output logic o_force_oscillator_use,
	output logic o_oscillator_enable,
	output logic o_deep_sleep,
	output logic [NUM_FUNCS-1:0] o_func_clk_gate,
	// Link side virtual wires
	input wire logic i_link_clk,
	input wire logic i_link_host_c10,
	output logic o_link_nonfatal_vw,
	output logic o_link_fatal_vw,
	output logic o_link_smi_n,
	output logic o_link_sci_n
);

	// ==========================================
	// Declarations
	logic [3:0] policy;
	logic nonfatal_wire_status;
	logic fatal_wire_status;
	logic smi_error_status;
	logic sci_error_status;
	logic force_oscillator_use;
	logic idle_clock_gating_enable;
	logic deep_sleep_enable;
	logic io_chk_meta;
	logic io_chk_sync;
	logic io_chk_last;
	logic lock_meta;
	logic oscillator_lock_flag;
	logic c10_meta;
	logic c10_sync;
	logic c10_last;
	logic io_check_event;
	logic raise_nonfatal;
	logic raise_fatal;
	logic raise_smi;
	logic raise_sci;
	logic wr_policy;
	logic wr_wire;
	logic wr_event;
	logic wr_power;
	logic clear_nonfatal_status;
	logic clear_fatal_status;
	logic clear_smi_error;
	logic clear_sci_error;
	logic all_idle;
	logic c10_fall;
	logic [7:0] next_rdata;
	bep_pkg::bep_power_state_type power_state;
	bep_pkg::bep_power_state_type next_power_state;
	logic [1:0] lk_nonfatal;
	logic [1:0] lk_fatal;
	logic [1:0] lk_smi;
	logic [1:0] lk_sci;

	// ==========================================
	// Pin synchronisers
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			io_chk_meta <= 1'b1;
			io_chk_sync <= 1'b1;
			io_chk_last <= 1'b1;
			lock_meta <= 1'b0;
			oscillator_lock_flag <= 1'b0;
		end else if (i_clk_en) begin
			io_chk_meta <= i_io_check_signal_n;
			io_chk_sync <= io_chk_meta;
			io_chk_last <= io_chk_sync;
			lock_meta <= i_oscillator_locked;
			oscillator_lock_flag <= lock_meta;
		end
	end

	// Host C10 wire from the link domain
	always_ff @(posedge i_ref_clk or posedge i_espi_rst) begin
		if (i_espi_rst) begin
			c10_meta <= 1'b0;
			c10_sync <= 1'b0;
			c10_last <= 1'b0;
		end else if (i_clk_en) begin
			c10_meta <= i_link_host_c10;
			c10_sync <= c10_meta;
			c10_last <= c10_sync;
		end
	end

	// ==========================================
	// Write decode
	assign wr_policy = i_cfg_req.wr && (i_cfg_req.index == `BEP_IDX_POLICY);
	assign wr_wire = i_cfg_req.wr && (i_cfg_req.index == `BEP_IDX_WIRE);
	assign wr_event = i_cfg_req.wr && (i_cfg_req.index == `BEP_IDX_EVENT);
	assign wr_power = i_cfg_req.wr && (i_cfg_req.index == `BEP_IDX_POWER);

	// Clear strobes from write-one bits
	// nonfatal clear strobe
	assign clear_nonfatal_status = wr_wire && i_cfg_req.wdata[`BEP_NONFATAL_CLR_BIT];
	assign clear_fatal_status = wr_wire && i_cfg_req.wdata[`BEP_FATAL_CLR_BIT];
	assign clear_sci_error = wr_event && i_cfg_req.wdata[`BEP_SCI_CLR_BIT];
	assign clear_smi_error = wr_event && i_cfg_req.wdata[`BEP_SMI_CLR_BIT];

	// ==========================================
	// Posted io check event and policy
	// falling io check in posted write
	assign io_check_event = i_posted_write_active && io_chk_last && !io_chk_sync;
	assign raise_nonfatal = io_check_event && (policy == `BEP_POL_NONFATAL);
	assign raise_fatal = io_check_event && (policy == `BEP_POL_FATAL);
	assign raise_smi = io_check_event && (policy == `BEP_POL_SMI);
	assign raise_sci = io_check_event && (policy == `BEP_POL_SCI);

	// Policy field, platform reset
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			policy <= `BEP_RST_POLICY;
		end else if (i_clk_en && wr_policy) begin
			policy <= i_cfg_req.wdata[`BEP_POLICY_MSB:0];
		end
	end

	// ==========================================
	// Error wire status, eSPI reset
	always_ff @(posedge i_ref_clk or posedge i_espi_rst) begin
		if (i_espi_rst) begin
			nonfatal_wire_status <= 1'b0;
			fatal_wire_status <= 1'b0;
		end else if (i_clk_en) begin
			if (raise_nonfatal) begin
				nonfatal_wire_status <= 1'b1;
			end else if (clear_nonfatal_status) begin
				nonfatal_wire_status <= 1'b0;
			end
			if (raise_fatal) begin
				fatal_wire_status <= 1'b1;
			end else if (clear_fatal_status) begin
				fatal_wire_status <= 1'b0;
			end
		end
	end

	// ==========================================
	// Error event status, platform reset
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			smi_error_status <= 1'b0;
			sci_error_status <= 1'b0;
		end else if (i_clk_en) begin
			if (raise_smi) begin
				smi_error_status <= 1'b1;
			end else if (clear_smi_error) begin
				smi_error_status <= 1'b0;
			end
			if (raise_sci) begin
				sci_error_status <= 1'b1;
			end else if (clear_sci_error) begin
				sci_error_status <= 1'b0;
			end
		end
	end

	// ==========================================
	// Power save control bits
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			force_oscillator_use <= 1'b0;
			idle_clock_gating_enable <= 1'b0;
			deep_sleep_enable <= 1'b0;
		end else if (i_clk_en && wr_power) begin
			force_oscillator_use <= i_cfg_req.wdata[`BEP_FORCE_OSC_BIT];
			idle_clock_gating_enable <= i_cfg_req.wdata[`BEP_IDLE_GATE_BIT];
			deep_sleep_enable <= i_cfg_req.wdata[`BEP_DEEP_SLEEP_BIT];
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_force_oscillator_use <= 1'b0;
		end else if (i_clk_en) begin
			o_force_oscillator_use <= force_oscillator_use;
		end
	end

	// ==========================================
	// Per function idle clock gating
	genvar gi;
	generate
		for (gi = 0; gi < NUM_FUNCS; gi++) begin : g_gate
			always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
				if (i_sys_rst) begin
					o_func_clk_gate[gi] <= 1'b0;
				end else if (i_clk_en) begin
					o_func_clk_gate[gi] <= idle_clock_gating_enable && i_func_idle[gi];
				end
			end
		end
	endgenerate

	// ==========================================
	// Deep sleep control
	assign all_idle = i_idle.espi && i_idle.lpc && i_idle.serirq && i_idle.lpc_clk;
	assign c10_fall = c10_last && !c10_sync;

	// Next power state
	always_comb begin
		next_power_state = power_state;
		case (power_state)
			bep_pkg::BEP_RUN: begin
				if (deep_sleep_enable && c10_sync && all_idle) begin
					next_power_state = bep_pkg::BEP_SLEEP;
				end
			end
			bep_pkg::BEP_SLEEP: begin
				if (c10_fall || !c10_sync || !all_idle) begin
					next_power_state = bep_pkg::BEP_WAKE;
				end
			end
			bep_pkg::BEP_WAKE: begin
				// Hold until the restarted oscillator is usable
				if (oscillator_lock_flag || force_oscillator_use) begin
					next_power_state = bep_pkg::BEP_RUN;
				end
			end
			default: begin
				next_power_state = bep_pkg::BEP_RUN;
			end
		endcase
	end

	// Power state register
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			power_state <= bep_pkg::BEP_RUN;
		end else if (i_clk_en) begin
			power_state <= next_power_state;
		end
	end

	// Oscillator enable and sleep flag
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_oscillator_enable <= 1'b1;
			o_deep_sleep <= 1'b0;
		end else if (i_clk_en) begin
			o_oscillator_enable <= (next_power_state != bep_pkg::BEP_SLEEP);
			o_deep_sleep <= (next_power_state == bep_pkg::BEP_SLEEP);
		end
	end

	// ==========================================
	// Read mux
	always_comb begin
		next_rdata = `BEP_RST_BYTE;
		case (i_cfg_req.index)
			`BEP_IDX_POLICY: begin
				next_rdata[`BEP_POLICY_MSB:0] = policy;
			end
			`BEP_IDX_WIRE: begin
				next_rdata[`BEP_NONFATAL_STS_BIT] = nonfatal_wire_status;
				next_rdata[`BEP_FATAL_STS_BIT] = fatal_wire_status;
			end
			`BEP_IDX_EVENT: begin
				next_rdata[`BEP_SCI_STS_BIT] = sci_error_status;
				next_rdata[`BEP_SMI_STS_BIT] = smi_error_status;
			end
			`BEP_IDX_REV: begin
				next_rdata = CHIP_REVISION;
			end
			`BEP_IDX_SUB: begin
				next_rdata = CHIP_SUB_ID;
			end
			`BEP_IDX_ID_LO: begin
				next_rdata = CHIP_ID_LOW;
			end
			`BEP_IDX_ID_HI: begin
				next_rdata = CHIP_ID_HIGH;
			end
			`BEP_IDX_LEG_ID: begin
				next_rdata = LEGACY_ID;
			end
			`BEP_IDX_LEG_REV: begin
				next_rdata = LEGACY_REV;
			end
			`BEP_IDX_POWER: begin
				next_rdata[`BEP_OSC_LOCK_BIT] = oscillator_lock_flag;
				next_rdata[`BEP_FORCE_OSC_BIT] = force_oscillator_use;
				next_rdata[`BEP_IDLE_GATE_BIT] = idle_clock_gating_enable;
				next_rdata[`BEP_DEEP_SLEEP_BIT] = deep_sleep_enable;
			end
			default: begin
				next_rdata = `BEP_RST_BYTE;
			end
		endcase
	end

	// Read data and valid, one cycle after strobe
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_cfg_rdata <= `BEP_RST_BYTE;
			o_cfg_rvalid <= 1'b0;
		end else if (i_clk_en) begin
			o_cfg_rvalid <= i_cfg_req.rd;
			if (i_cfg_req.rd) begin
				o_cfg_rdata <= next_rdata;
			end
		end
	end

	// ==========================================
	// Link domain wire drivers
	// Levels cross by two flip-flops each
	always_ff @(posedge i_link_clk or posedge i_espi_rst) begin
		if (i_espi_rst) begin
			lk_nonfatal <= 2'b00;
			lk_fatal <= 2'b00;
			lk_smi <= 2'b00;
			lk_sci <= 2'b00;
		end else begin
			lk_nonfatal <= {lk_nonfatal[0], nonfatal_wire_status};
			lk_fatal <= {lk_fatal[0], fatal_wire_status};
			lk_smi <= {lk_smi[0], smi_error_status};
			lk_sci <= {lk_sci[0], sci_error_status};
		end
	end

	// Wire levels toward the host
	assign o_link_nonfatal_vw = lk_nonfatal[1];
	assign o_link_fatal_vw = lk_fatal[1];
	assign o_link_smi_n = !lk_smi[1];
	assign o_link_sci_n = !lk_sci[1];

endmodule : bep_top

// file: tb/bep_top_monitor.sv
// Purpose: port checks of the bridge register bank
// Assumes: bound into bep_top
// Notes: reference clock domain only
`timescale 1ns/1ps

module bep_top_monitor #(
	parameter int NUM_FUNCS = 4
) (
	// Clock, reset, enable
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic i_clk_en,
	// Portal
	input wire bep_pkg::bep_cfg_req_type i_cfg_req,
	input wire logic [7:0] o_cfg_rdata,
	input wire logic o_cfg_rvalid,
	// Power control
	input wire bep_pkg::bep_idle_type i_idle,
	input wire logic [NUM_FUNCS-1:0] i_func_idle,
	input wire logic o_oscillator_enable,
	input wire logic o_deep_sleep,
	input wire logic [NUM_FUNCS-1:0] o_func_clk_gate
);
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_sys_rst);

	// ==========================================
	// Portal answers
	// read answer pulse
	rd_answer_a: assert property (i_cfg_req.rd && i_clk_en |=> o_cfg_rvalid)
		else $error("read gave no answer");
	no_answer_a: assert property (i_clk_en && !i_cfg_req.rd |=> !o_cfg_rvalid)
		else $error("answer without read");
	wire_clr_a: assert property (o_cfg_rvalid && $past(i_cfg_req.index) == 8'h12
		|-> (o_cfg_rdata & 8'hee) == 8'h00) else $error("wire register bits wrong");
	event_clr_a: assert property (o_cfg_rvalid && $past(i_cfg_req.index) == 8'h13
		|-> (o_cfg_rdata & 8'hee) == 8'h00) else $error("event register bits wrong");
	policy_rsvd_a: assert property (o_cfg_rvalid && $past(i_cfg_req.index) == 8'h10
		|-> o_cfg_rdata[7:4] == 4'h0) else $error("policy upper bits set");
	power_rsvd_a: assert property (o_cfg_rvalid && $past(i_cfg_req.index) == 8'h2a
		|-> o_cfg_rdata[5:2] == 4'h0) else $error("power reserved bits set");

	// ==========================================
	// Power save
	// oscillator off asleep
	osc_off_a: assert property (o_deep_sleep |-> !o_oscillator_enable)
		else $error("oscillator on in deep sleep");
	sleep_entry_a: assert property ($rose(o_deep_sleep) |-> $past(i_idle) == 4'hf)
		else $error("sleep entered while busy");
	wake_a: assert property (o_deep_sleep && i_clk_en && i_idle != 4'hf |=> !o_deep_sleep)
		else $error("no wake on activity");
	gate_idle_a: assert property ($past(i_clk_en)
		|-> (o_func_clk_gate & ~$past(i_func_idle)) == '0) else $error("busy function gated");

	// Main scenarios reached
	cover property ($rose(o_deep_sleep));
	cover property (o_cfg_rvalid && $past(i_cfg_req.index) == 8'h13 && o_cfg_rdata[0]);
	cover property (|o_func_clk_gate);
endmodule : bep_top_monitor

bind bep_top bep_top_monitor #(
	.NUM_FUNCS(NUM_FUNCS)
) mon_u (
	.i_ref_clk,
	.i_sys_rst,
	.i_clk_en,
	.i_cfg_req,
	.o_cfg_rdata,
	.o_cfg_rvalid,
	.i_idle,
	.i_func_idle,
	.o_oscillator_enable,
	.o_deep_sleep,
	.o_func_clk_gate
);

// file: tb/bep_host_model.sv
// Purpose: host side of the virtual wire link
// Assumes: link clock stands still when the bench stops it
// Notes: wires seen as {nonfatal, fatal, smi, sci}, high = asserted
`timescale 1ns/1ps

module bep_host_model (
	// Link clock and reset
	input wire logic i_link_clk,
	input wire logic i_espi_rst,
	// Bench side
	input wire logic i_c10_req,
	output logic [3:0] o_seen,
	// Bridge side
	input wire logic [3:0] i_wires,
	output logic o_host_c10
);
	always_ff @(posedge i_link_clk or posedge i_espi_rst) begin
		if (i_espi_rst) begin
			o_host_c10 <= 1'b0;
			o_seen <= 4'h0;
		end else begin
			o_host_c10 <= i_c10_req;
			o_seen <= i_wires;
		end
	end
endmodule : bep_host_model

// file: tb/bep_top_test.sv
// Purpose: self-checking bench of the bridge register bank
// Assumes: host model on the link side
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/1ps

module bep_top_test;
	localparam logic [7:0] ID [6] = '{8'ha1, 8'hb2, 8'hc3, 8'hd4, 8'he5, 8'hf6}; // Arbitrary
	logic clk = 1'b0;
	logic lclk = 1'b0;
	logic link_run = 1'b1;
	logic rst = 1'b1;
	logic espi_rst = 1'b1;
	logic clk_en = 1'b1;
	bep_pkg::bep_cfg_req_type req = '0;
	bep_pkg::bep_idle_type idle = 4'hf;
	logic [3:0] func_idle = 4'h0;
	logic chk_n = 1'b1;
	logic posted = 1'b0;
	logic locked = 1'b1;
	logic c10_req = 1'b0;
	logic host_c10, rvalid, force_osc, osc_en, sleep, nf_vw, f_vw, smi_n, sci_n;
	logic [7:0] rdata;
	logic [3:0] gate, seen;
	int errors = 0;
	int samples_checked = 0;
	int cycles = 0;

	// Clocks, link clock stops when not running
	initial begin
		forever #4 clk = ~clk;
	end
	initial begin
		#1.7;
		forever #3 lclk = link_run ? ~lclk : 1'b0;
	end

	bep_top #(.CHIP_REVISION(ID[0]), .CHIP_SUB_ID(ID[1]), .CHIP_ID_LOW(ID[2]),
		.CHIP_ID_HIGH(ID[3]), .LEGACY_ID(ID[4]), .LEGACY_REV(ID[5])) dut_u (
		.i_ref_clk(clk), .i_sys_rst(rst), .i_espi_rst(espi_rst), .i_clk_en(clk_en),
		.i_cfg_req(req), .o_cfg_rdata(rdata), .o_cfg_rvalid(rvalid),
		.i_io_check_signal_n(chk_n), .i_posted_write_active(posted),
		.i_oscillator_locked(locked), .i_idle(idle), .i_func_idle(func_idle),
		.o_force_oscillator_use(force_osc), .o_oscillator_enable(osc_en),
		.o_deep_sleep(sleep), .o_func_clk_gate(gate), .i_link_clk(lclk),
		.i_link_host_c10(host_c10), .o_link_nonfatal_vw(nf_vw), .o_link_fatal_vw(f_vw),
		.o_link_smi_n(smi_n), .o_link_sci_n(sci_n));

	bep_host_model host_u (.i_link_clk(lclk), .i_espi_rst(espi_rst), .i_c10_req(c10_req),
		.o_seen(seen), .i_wires({nf_vw, f_vw, ~smi_n, ~sci_n}), .o_host_c10(host_c10));

	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			results();
		end
	end

	task automatic results;
		$display("checked %0d, errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : results

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task automatic check(input logic [7:0] s, input logic [7:0] e);
		samples_checked++;
		if (s !== e) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req = '{wr: 1'b1, rd: 1'b0, index: a, wdata: d};
		tick(1);
		req = '0;
		tick(1);
	endtask : wr

	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		req = '{wr: 1'b0, rd: 1'b1, index: a, wdata: 8'h00};
		tick(1);
		req = '0;
		check(8'(rvalid), 8'h01);
		check(rdata, e);
		tick(1);
	endtask : rdchk

	// Io check pin pulse during or outside a posted write
	task automatic pulse(input logic p);
		posted = p;
		chk_n = 1'b0;
		tick(4);
		chk_n = 1'b1;
		posted = 1'b0;
		tick(8);
	endtask : pulse

	// Reset values, identity, read-only and unmapped places
	task automatic t_ident;
		rdchk(8'h10, 8'h00);
		rdchk(8'h12, 8'h00);
		rdchk(8'h13, 8'h00);
		rdchk(8'h2a, 8'h80);
		for (int i = 0; i < 6; i++) begin
			rdchk(8'h1c + 8'(i), ID[i]);
		end
		wr(8'h1c, 8'h00);
		wr(8'h11, 8'hff);
		rdchk(8'h1c, ID[0]);
		rdchk(8'h11, 8'h00);
	endtask : t_ident

	// Every policy code, wires at the host, clears
	task automatic t_policy;
		wr(8'h10, 8'hff);
		rdchk(8'h10, 8'h0f);
		for (int c = 0; c < 6; c++) begin
			wr(8'h10, 8'(c));
			pulse(1'b1);
			rdchk(8'h12, {3'h0, c == 1, 3'h0, c == 2});
			rdchk(8'h13, {3'h0, c == 4, 3'h0, c == 3});
			check({4'h0, seen}, {4'h0, c == 1, c == 2, c == 3, c == 4});
			wr(8'h12, 8'h22);
			wr(8'h13, 8'h22);
			tick(8);
			rdchk(8'h12, 8'h00);
			rdchk(8'h13, 8'h00);
			check({4'h0, seen}, 8'h00);
		end
		wr(8'h10, 8'h01);
		pulse(1'b0);
		rdchk(8'h12, 8'h00);
		wr(8'h10, 8'h02);
		pulse(1'b1);
		espi_rst = 1'b1;
		tick(2);
		espi_rst = 1'b0;
		rdchk(8'h12, 8'h00);
		clk_en = 1'b0;
		wr(8'h10, 8'h03);
		clk_en = 1'b1;
		rdchk(8'h10, 8'h02);
	endtask : t_policy

	// Force, idle gating and lock flag with the link stopped
	task automatic t_power;
		link_run = 1'b0;
		wr(8'h2a, 8'hff);
		rdchk(8'h2a, 8'hc3);
		check(8'(force_osc), 8'h01);
		func_idle = 4'h5;
		tick(3);
		check(8'(gate), 8'h05);
		wr(8'h2a, 8'h00);
		locked = 1'b0;
		tick(4);
		check({force_osc, 3'h0, gate}, 8'h00);
		rdchk(8'h2a, 8'h00);
		locked = 1'b1;
		link_run = 1'b1;
	endtask : t_power

	// Deep sleep entry and both wake causes
	task automatic t_sleep;
		wr(8'h2a, 8'h01);
		c10_req = 1'b1;
		tick(10);
		check({sleep, osc_en}, 8'h02);
		idle.lpc = 1'b0;
		tick(2);
		check({sleep, osc_en}, 8'h01);
		idle.lpc = 1'b1;
		tick(4);
		check({sleep, osc_en}, 8'h02);
		// Unlocked wake holds until the force bit is set
		locked = 1'b0;
		tick(3);
		idle.lpc = 1'b0;
		tick(2);
		idle.lpc = 1'b1;
		tick(4);
		check({sleep, osc_en}, 8'h01);
		wr(8'h2a, 8'h41);
		tick(4);
		check({sleep, osc_en}, 8'h02);
		locked = 1'b1;
		c10_req = 1'b0;
		tick(10);
		check({sleep, osc_en}, 8'h01);
		wr(8'h2a, 8'h00);
		c10_req = 1'b1;
		tick(10);
		check({sleep, osc_en}, 8'h01);
		c10_req = 1'b0;
	endtask : t_sleep

	// Main sequence
	initial begin
		repeat (12) @(posedge clk);
		#1;
		rst = 1'b0;
		espi_rst = 1'b0;
		tick(4);
		t_ident();
		t_policy();
		t_power();
		t_sleep();
		results();
	end
endmodule : bep_top_test
